/* File: testbench/adc_mon_sva.sv */
`timescale 1ns/100ps
module adc_mon_sva
    import adc_mon_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Converter and events
    input wire logic conv_store,
    input wire logic [3:0] conv_slot,
    input wire logic monitor_hit
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_resp_up;
        !awready && !wready ##1 bvalid && !awready && !wready;
    endsequence
    property p_wr_answer;
        s_wr_taken |=> s_resp_up;
    endproperty
    property p_b_hold;
        bvalid && !bready |=> bvalid;
    endproperty
    property p_rd_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_rd_unused;
        rvalid |-> rdata[31:16] == 16'h0000;
    endproperty
    property p_hit_cause;
        monitor_hit |-> $past(conv_store) && $past(conv_slot) <= 4'h8;
    endproperty
    property p_bad_slot;
        conv_store && conv_slot > 4'h8 |=> !monitor_hit;
    endproperty
    property p_hit_single;
        monitor_hit && !conv_store |=> !monitor_hit;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response missing");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response missing");
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    a_rd_unused: assert property (p_rd_unused)
        else $error("upper read bits not zero");
    a_hit_cause: assert property (p_hit_cause)
        else $error("hit without store");
    a_bad_slot: assert property (p_bad_slot)
        else $error("hit on unused slot");
    a_hit_single: assert property (p_hit_single)
        else $error("hit longer than one cycle");
endmodule : adc_mon_sva

bind adc_result_monitor adc_mon_sva u_adc_mon_sva (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .arvalid, .arready, .rvalid, .rready, .rdata,
    .conv_store, .conv_slot, .monitor_hit
);

/* File: testbench/adc_result_monitor_test.sv */
`timescale 1ns/100ps
module adc_result_monitor_test
    import adc_mon_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, monitor_hit, irq;
    logic [1:0] bresp, rresp, r;
    logic conv_store;
    logic [3:0] conv_slot;
    logic [RES_W-1:0] conv_value;
    int failures = 0;
    int check_count = 0;
    int hit_count = 0;
    int i;
    logic [7:0] radr [6] = '{OFF_CONTROL, OFF_COMPARE, OFF_RESULT_BASE,
        OFF_PRIORITY, OFF_INT_STATUS, OFF_INT_ENABLE};
    // Control, slot, value, expected hit
    logic [20:0] tc [6] = '{{6'h07, 4'h3, 10'h100, 1'b0},
        {6'h07, 4'h2, 10'h000, 1'b0}, {6'h27, 4'h3, 10'h101, 1'b1},
        {6'h27, 4'h3, 10'h0ff, 1'b0}, {6'h26, 4'h3, 10'h3ff, 1'b0},
        {6'h3f, 4'h9, 10'h3ff, 1'b0}};

    always #2.5 aclk = ~aclk;

    // Mid-cycle sampling keeps clear of the launching edge
    always @(negedge aclk) begin
        if (monitor_hit === 1'b1) begin
            hit_count++;
        end
    end

    adc_result_monitor u_adc_result_monitor (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .conv_store, .conv_slot, .conv_value,
        .monitor_hit, .irq);
    conv_core_model u_conv_core_model (.aclk, .conv_store, .conv_slot,
        .conv_value);

    function automatic logic [31:0] res(input logic [9:0] v,
                                        input logic o, s);
        return {16'h0, v, 4'h0, o, s};
    endfunction : res

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            #1;
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            rs = bresp;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
            end
        end while (!tb);
        bready <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            #1;
            ta = arvalid && arready;
            tr = rvalid && rready;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) begin
                arvalid <= 1'b0;
                rready <= 1'b1;
            end
        end while (!tr);
        rready <= 1'b0;
        #1;
    endtask : rd

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(radr[i], d, r);
            chk("reset", d, 32'h0);
        end
        wr(OFF_CONTROL, 32'hffff_ffff, r);
        rd(OFF_CONTROL, d, r);
        chk("ctl mask", d, 32'h3f);
        wr(OFF_RESULT_BASE, 32'hffff_ffff, r);
        rd(OFF_RESULT_BASE, d, r);
        chk("res ro", d, 32'h0);
        wr(OFF_CONTROL, 32'h0, r);
        wr(OFF_INT_ENABLE, 32'h2, r);
        u_conv_core_model.put(4'h0, 10'h2a5, 0);
        u_conv_core_model.put(4'h1, 10'h155, 3);
        u_conv_core_model.put(4'h1, 10'h3c3, 0);
        rd(OFF_RESULT_BASE, d, r);
        chk("slot0", d, res(10'h2a5, 1'b0, 1'b1));
        rd(OFF_RESULT_BASE + 8'h04, d, r);
        chk("slot1", d, res(10'h3c3, 1'b1, 1'b1));
        chk("ovr irq", {31'h0, irq}, 32'h1);
        rd(OFF_RESULT_BASE + 8'h04, d, r);
        chk("slot1 clr", d, res(10'h3c3, 1'b0, 1'b0));
        wr(OFF_INT_CLEAR, 32'h3, r);
        chk("irq clr", {31'h0, irq}, 32'h0);
        wr(OFF_COMPARE, 32'h100, r);
        wr(OFF_INT_ENABLE, 32'h1, r);
        for (i = 0; i < 16; i++) begin
            wr(OFF_CONTROL, {26'h0, 1'b0, i[3:0], 1'b1}, r);
            u_conv_core_model.put(i[3] ? 4'h8 : i[3:0], 10'h0ff, i % 3);
            rd(OFF_INT_STATUS, d, r);
            chk("sel hit", {31'h0, d[0]}, 32'h1);
            chk("sel irq", {31'h0, irq}, 32'h1);
            wr(OFF_INT_CLEAR, 32'h1, r);
        end
        foreach (tc[j]) begin
            wr(OFF_CONTROL, {26'h0, tc[j][20:15]}, r);
            u_conv_core_model.put(tc[j][14:11], tc[j][10:1], 0);
            rd(OFF_INT_STATUS, d, r);
            chk("mon", 32'(d[0]), 32'(tc[j][0]));
            wr(OFF_INT_CLEAR, 32'h1, r);
        end
        wr(OFF_INT_ENABLE, 32'h0, r);
        wr(OFF_CONTROL, 32'h7, r);
        u_conv_core_model.put(4'h3, 10'h000, 1);
        rd(OFF_INT_STATUS, d, r);
        chk("masked", {30'h0, d[0], irq}, 32'h2);
        wr(OFF_SOFT_RESET, {30'h0, SRST_FIRST}, r);
        wr(OFF_SOFT_RESET, {30'h0, SRST_SECOND}, r);
        rd(OFF_CONTROL, d, r);
        chk("srst ctl", d, 32'h0);
        rd(OFF_RESULT_BASE + 8'h0c, d, r);
        chk("srst res", d, 32'h0);
        wr(8'h80, 32'h1, r);
        chk("bad wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        rd(8'h80, d, r);
        chk("bad rd", {30'h0, r}, {30'h0, RESP_SLVERR});
        // Sixteen select hits, one above-compare hit, one masked hit
        chk("hit count", 32'(hit_count), 32'h12);
        stop_test();
    end
endmodule : adc_result_monitor_test

/* File: testbench/conv_core_model.sv */
`timescale 1ns/100ps
module conv_core_model
    import adc_mon_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Results
    output logic conv_store,
    output logic [3:0] conv_slot,
    output logic [RES_W-1:0] conv_value
);
    initial begin
        conv_store = 1'b0;
        conv_slot = 4'h0;
        conv_value = 10'h000;
    end

    task automatic put(input logic [3:0] s, input logic [RES_W-1:0] v,
                       input int gap);
        repeat (gap + 1) @(posedge aclk);
        conv_store <= 1'b1;
        conv_slot <= s;
        conv_value <= v;
        @(posedge aclk);
        conv_store <= 1'b0;
        // Stale data inverted so it never passes as a result
        conv_value <= ~v;
        #1;
    endtask : put
endmodule : conv_core_model

/* File: verilog/adc_mon_pkg.sv */
// Function
// - The monitor compares only while its enable bit 0 is set.
// - With direction bit 5 clear, a result below the compare value hits.
// - With direction bit 5 set, a result above the compare value hits.
// - Select bits 4:1 pick slots 0 to 7, and any code 1xxx the priority slot.
// - Each result register shows its 10-bit result, read-only, in bits 15:6.
// - Overrun bit 1 sets when a new result replaces an unread one.
// - Reading a result register clears its overrun bit.
// - Stored bit 0 sets whenever a result is written into the register.
// - Reading the result clears the stored bit, unless a new result is stored in the same cycle.
// - Writing 10 then 01 to the soft reset field resets all registers.
package adc_mon_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COMPARE = 8'h04;
    localparam logic [7:0] OFF_RESULT_BASE = 8'h10;
    localparam logic [7:0] OFF_PRIORITY = 8'h30;
    localparam logic [7:0] OFF_INT_STATUS = 8'h34;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h38;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h3c;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h40;
    localparam int unsigned CTL_W = 6;
    localparam int unsigned CTL_EN_BIT = 0;
    localparam int unsigned CTL_SEL_LSB = 1;
    localparam int unsigned CTL_SEL_W = 4;
    localparam int unsigned CTL_DIR_BIT = 5;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam int unsigned RES_W = 10;
    localparam int unsigned RES_VAL_LSB = 6;
    localparam int unsigned RES_OVR_BIT = 1;
    localparam int unsigned RES_STORED_BIT = 0;
    localparam logic [9:0] CMP_RESET = 10'h000;
    localparam int unsigned NUM_SLOTS = 9;
    localparam logic [3:0] PRIO_SLOT = 4'h8;
    localparam int unsigned INT_W = 2;
    localparam int unsigned INT_MON_BIT = 0;
    localparam int unsigned INT_OVR_BIT = 1;
    localparam logic [1:0] INT_RESET = 2'h0;
    localparam logic [1:0] SRST_FIRST = 2'h2;
    localparam logic [1:0] SRST_SECOND = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [3:0] sel_to_slot(input logic [3:0] sel);
        return sel[3] ? PRIO_SLOT : {1'b0, sel[2:0]};
    endfunction : sel_to_slot
endpackage : adc_mon_pkg

/* File: verilog/adc_result_monitor.sv */
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module adc_result_monitor
    import adc_mon_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Converter core
    input wire logic conv_store,
    input wire logic [3:0] conv_slot,
    input wire logic [RES_W-1:0] conv_value,
    // Events
    output logic monitor_hit,
    output logic irq
);
    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic [RES_W-1:0] cmp;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_enable;
        logic srst_armed;
        logic srst;
        logic hit;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t r;
    state_t nxt;

    logic [31:0] slot_word [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_store;
    logic [NUM_SLOTS-1:0] read_clr;
    logic [NUM_SLOTS-1:0] ovr_evt;
    logic mon_hit;
    logic ar_hs;
    logic [ADDR_W-1:0] rd_addr;
    logic rd_is_result;
    logic [3:0] rd_slot;
    logic [7:0] rd_offset;

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // Read and write decode share one notion of the slot window
    function automatic logic in_result_range(input logic [ADDR_W-1:0] a);
        return (a >= OFF_RESULT_BASE) && (a <= OFF_PRIORITY);
    endfunction : in_result_range

    // Handshake outputs straight from state
    assign awready = !r.aw_held && !r.bvalid;
    assign wready = !r.w_held && !r.bvalid;
    assign arready = !r.rvalid;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign rvalid = r.rvalid;
    assign rresp = r.rresp;
    assign rdata = r.rdata;
    assign monitor_hit = r.hit;
    assign irq = |(r.int_status & r.int_enable);

    assign ar_hs = arvalid && arready;
    assign rd_addr = {araddr[ADDR_W-1:2], 2'b00};
    assign rd_offset = rd_addr - OFF_RESULT_BASE;
    assign rd_is_result = in_result_range(rd_addr);
    assign rd_slot = rd_offset[5:2];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            assign slot_store[gi] = conv_store
                                 && (conv_slot == 4'(gi));
            // Read of the register clears both flags; a same-cycle store keeps stored set
            assign read_clr[gi] = ar_hs && rd_is_result
                               && (rd_slot == 4'(gi));
            assign ovr_evt[gi] = slot_store[gi]
                              && slot_word[gi][RES_STORED_BIT]
                              && !read_clr[gi];
            result_slot u_slot (
                .aclk(aclk),
                .aresetn(aresetn),
                .soft_rst(r.srst),
                .store(slot_store[gi]),
                .store_value(conv_value),
                .read_clr(read_clr[gi]),
                .word(slot_word[gi])
            );
        end
    endgenerate

    monitor_compare u_cmp (
        .enable(r.ctl[CTL_EN_BIT]),
        .direction(r.ctl[CTL_DIR_BIT]),
        .target_select(r.ctl[CTL_SEL_LSB +: CTL_SEL_W]),
        .compare_value(r.cmp),
        .store(conv_store && !r.srst),
        .store_slot(conv_slot),
        .store_value(conv_value),
        .hit(mon_hit)
    );

    always_comb begin
        logic [ADDR_W-1:0] wa;
        logic [31:0] merged;
        logic [INT_W-1:0] clr;
        logic [INT_W-1:0] set;
        wa = '0;
        merged = '0;
        clr = '0;
        set = '0;
        nxt = r;
        nxt.srst = 1'b0;
        nxt.hit = mon_hit;

        // Write address and data are taken in either order
        if (awvalid && awready) begin
            nxt.aw_held = 1'b1;
            nxt.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt.w_held = 1'b1;
            nxt.wdata = wdata;
            nxt.wstrb = wstrb;
        end
        if (r.bvalid && bready) begin
            nxt.bvalid = 1'b0;
        end

        if (r.aw_held && r.w_held && !r.bvalid) begin
            wa = {r.awaddr[ADDR_W-1:2], 2'b00};
            nxt.aw_held = 1'b0;
            nxt.w_held = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = RESP_OKAY;
            merged = merge_strb(32'h0000_0000, r.wdata, r.wstrb);
            unique case (wa)
                OFF_CONTROL: begin
                    merged = merge_strb(32'(r.ctl), r.wdata, r.wstrb);
                    nxt.ctl = merged[CTL_W-1:0];
                end
                OFF_COMPARE: begin
                    merged = merge_strb(32'(r.cmp), r.wdata, r.wstrb);
                    nxt.cmp = merged[RES_W-1:0];
                end
                OFF_INT_ENABLE: begin
                    merged = merge_strb(32'(r.int_enable), r.wdata,
                                        r.wstrb);
                    nxt.int_enable = merged[INT_W-1:0];
                end
                OFF_INT_CLEAR: begin
                    clr = merged[INT_W-1:0];
                end
                OFF_SOFT_RESET: begin
                    if (r.wstrb[0]) begin
                        if (merged[1:0] == SRST_FIRST) begin
                            nxt.srst_armed = 1'b1;
                        end else if (merged[1:0] == SRST_SECOND
                                     && r.srst_armed) begin
                            nxt.srst_armed = 1'b0;
                            nxt.srst = 1'b1;
                        end else begin
                            nxt.srst_armed = 1'b0;
                        end
                    end
                end
                OFF_INT_STATUS: begin
                end
                default: begin
                    // Result slots are read-only; other holes refuse
                    if (!in_result_range(wa)) begin
                        nxt.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end

        if (r.rvalid && rready) begin
            nxt.rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt.rvalid = 1'b1;
            nxt.rresp = RESP_OKAY;
            nxt.rdata = 32'h0000_0000;
            if (rd_is_result) begin
                nxt.rdata = slot_word[rd_slot];
            end else begin
                unique case (rd_addr)
                    OFF_CONTROL: nxt.rdata = 32'(r.ctl);
                    OFF_COMPARE: nxt.rdata = 32'(r.cmp);
                    OFF_INT_STATUS: nxt.rdata = 32'(r.int_status);
                    OFF_INT_ENABLE: nxt.rdata = 32'(r.int_enable);
                    OFF_INT_CLEAR: nxt.rdata = 32'h0000_0000;
                    OFF_SOFT_RESET: nxt.rdata = 32'h0000_0000;
                    default: nxt.rresp = RESP_SLVERR;
                endcase
            end
        end

        // Hardware set beats a software clear in the same cycle
        set[INT_MON_BIT] = mon_hit;
        set[INT_OVR_BIT] = |ovr_evt;
        nxt.int_status = (r.int_status & ~clr) | set;

        // Bus state survives so an open transfer still completes
        if (r.srst) begin
            nxt.ctl = CTL_RESET;
            nxt.cmp = CMP_RESET;
            nxt.int_status = INT_RESET;
            nxt.int_enable = INT_RESET;
            nxt.srst_armed = 1'b0;
            nxt.hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end
endmodule : adc_result_monitor

/* File: verilog/monitor_compare.sv */
`timescale 1ns/100ps
module monitor_compare
    import adc_mon_pkg::*;
(
    // Monitor settings
    input wire logic enable,
    input wire logic direction,
    input wire logic [CTL_SEL_W-1:0] target_select,
    input wire logic [RES_W-1:0] compare_value,
    // Result being stored
    input wire logic store,
    input wire logic [3:0] store_slot,
    input wire logic [RES_W-1:0] store_value,
    // Comparison outcome
    output logic hit
);
    logic targeted;
    logic beyond;

    // Only a fresh store is judged, so a held result never repeats
    assign targeted = store && (store_slot == sel_to_slot(target_select));
    assign beyond = direction ? (store_value > compare_value)
                              : (store_value < compare_value);
    assign hit = enable && targeted && beyond;
endmodule : monitor_compare

/* File: verilog/result_slot.sv */
`timescale 1ns/100ps
module result_slot
    import adc_mon_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_rst,
    // Converter side
    input wire logic store,
    input wire logic [RES_W-1:0] store_value,
    // Software side
    input wire logic read_clr,
    output logic [31:0] word
);
    typedef struct packed {
        logic [RES_W-1:0] value;
        logic ovr;
        logic stored;
    } slot_t;

    slot_t slot_r;
    slot_t slot_nxt;

    always_comb begin
        slot_nxt = slot_r;
        if (soft_rst) begin
            slot_nxt = '0;
        end else begin
            if (store) begin
                slot_nxt.value = store_value;
                slot_nxt.stored = 1'b1;
            end else if (read_clr) begin
                slot_nxt.stored = 1'b0;
            end
            // Same-cycle read took the old value, so no loss
            if (store && slot_r.stored && !read_clr) begin
                slot_nxt.ovr = 1'b1;
            end else if (read_clr) begin
                slot_nxt.ovr = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_r <= '0;
        end else begin
            slot_r <= slot_nxt;
        end
    end

    always_comb begin
        word = '0;
        word[RES_VAL_LSB +: RES_W] = slot_r.value;
        word[RES_OVR_BIT] = slot_r.ovr;
        word[RES_STORED_BIT] = slot_r.stored;
    end
endmodule : result_slot
